/* File: inc/dwb_pkg.sv */
/*
  Constants, field layouts and carrier types for the write burst path.
  Assumes three users: hdl/dwb_write_path.sv and the two bench modules, with word-aligned Avalon-MM offsets.
*/
package dwb_pkg;

  // ------------------------------------------------------------
  // Register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [4:0] OFS_CFG = 5'h00;
  localparam logic [4:0] OFS_STAT = 5'h04;
  localparam logic [4:0] OFS_BURSTS = 5'h08;

  // Status bit positions
  localparam int ST_OPEN = 0;
  localparam int ST_CRC_PERSIST = 4;
  localparam int ST_MASK_ACTIVE = 5;
  localparam int ST_GAP_ERR = 6;
  localparam int ST_CWL_ERR = 7;

  // ------------------------------------------------------------
  // Burst length mode field values
  // ------------------------------------------------------------
  localparam logic [1:0] BM_FIX8 = 2'h0;
  localparam logic [1:0] BM_OTF = 2'h1;
  localparam logic [1:0] BM_CHOP4 = 2'h2;

  // Last beat pair index of each burst kind
  localparam logic [1:0] PAIR_LAST_8 = 2'h3;
  localparam logic [1:0] PAIR_LAST_4 = 2'h1;

  // x8 organisation: the shared pin can act as a lane mask
  localparam logic HAS_MASK = 1'b1;

  localparam int DL_DEPTH = 32;
  localparam int BANKS = 4;
  localparam int MEM_BYTES = 128;

  // Lowest column latency for the clock range; forbidden with long preamble
  localparam logic [4:0] CWL_LOWEST = 5'h09;
  // Gap count seen when two writes are five clocks apart
  localparam logic [2:0] GAP_FIVE = 3'h4;
  localparam logic [2:0] GAP_SAT = 3'h7;

  localparam logic [4:0] AL_RST = 5'h00;
  localparam logic [4:0] CWL_RST = 5'h09;
  localparam logic [4:0] WR_RST = 5'h0C;

  // Commands on the link
  typedef enum logic [1:0] {DWB_NOP, DWB_ACT, DWB_WR, DWB_PRE} dwb_cmd_e;

  // Configuration word, low bits of the CFG register
  typedef struct packed {
    logic pre2;
    logic [4:0] wr_rec;
    logic [4:0] write_column_latency;
    logic [4:0] al;
    logic crc_en;
    logic inv_en;
    logic mask_en;
    logic [1:0] bmode;
  } dwb_cfg_s;
  localparam int CFG_W = 21;

  localparam dwb_cfg_s CFG_RST = '{pre2: 1'b0, wr_rec: WR_RST, write_column_latency: CWL_RST,
    al: AL_RST, crc_en: 1'b0, inv_en: 1'b0, mask_en: 1'b0, bmode: BM_FIX8};

  // One accepted write command travelling down the latency line
  typedef struct packed {
    logic valid;
    logic bl8;
    logic ac;
    logic [1:0] bank;
    logic [1:0] slot;
  } dwb_wcmd_s;

endpackage

/* File: hdl/dwb_write_path.sv */
/*
  Write burst path of the memory device: latency line, beat capture with
  lane masking or inversion, bank open/close tracking and an Avalon-MM
  register slave. Assumes I_LCLK is the controller's free-running clock and
  that CFG is only rewritten while no write is in flight.
*/
`timescale 1ns/1ns
module dwb_write_path
  import dwb_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_RST_N,
  input wire logic [4:0] I_ADDRESS,
  input wire logic I_READ,
  input wire logic I_WRITE,
  input wire logic [31:0] I_WRITEDATA,
  input wire logic [3:0] I_BYTEENABLE,
  output logic O_WAITREQUEST,
  output logic [31:0] O_READDATA,
  input wire logic I_LCLK,
  input wire logic [1:0] I_CMD,
  input wire logic [1:0] I_BANK,
  input wire logic [1:0] I_SLOT,
  input wire logic I_A10,
  input wire logic I_A12,
  input wire logic [15:0] I_DQ,
  input wire logic [1:0] I_MASK_N,
  input wire logic [6:0] I_PEEK_ADDR,
  output logic [3:0] O_BANK_OPEN,
  output logic [7:0] O_PEEK_DATA
);

  // ------------------------------------------------------------
  // State types
  // ------------------------------------------------------------
  typedef struct packed {
    dwb_cfg_s cfg;
    logic wtreq;
    logic [31:0] rdata;
    logic [3:0] open_m;
    logic [3:0] open_s;
    logic [1:0] err_m;
    logic [1:0] err_s;
    logic [2:0] tg;
    logic [15:0] bursts;
  } dwb_sys_s;

  typedef struct packed {
    dwb_cfg_s cfg_m;
    dwb_cfg_s cfg_l;
    dwb_wcmd_s [DL_DEPTH-1:0] dl;
    dwb_wcmd_s cur;
    logic busy;
    logic [1:0] pair;
    logic tgl;
    logic [3:0] open;
    logic [3:0] pend;
    logic [3:0][4:0] rec;
    logic [2:0] gap;
    logic [1:0] err;
    logic [7:0] peek;
  } dwb_lnk_s;

  localparam dwb_sys_s SYS_RST = '{cfg: CFG_RST, wtreq: 1'b1, default: '0};
  localparam dwb_lnk_s LNK_RST = '{cfg_m: CFG_RST, cfg_l: CFG_RST, default: '0};

  dwb_sys_s s_q;
  dwb_sys_s s_d;
  dwb_lnk_s l_q;
  dwb_lnk_s l_d;
  logic [1:0] lrst_q;
  logic lrst_n;
  logic [7:0] mem [MEM_BYTES];

  // Link-side combinational results
  dwb_wcmd_s tap;
  dwb_wcmd_s cc;
  dwb_wcmd_s new_cmd;
  logic start;
  logic cap;
  logic done;
  logic [1:0] pidx;
  logic [5:0] wl;
  logic [4:0] wl_idx;
  logic [6:0] waddr;
  logic we0;
  logic we1;
  logic [7:0] wd0;
  logic [7:0] wd1;

  // ------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------
  // Burst length from mode field and address bit 12
  function automatic logic burst_is8(input dwb_cfg_s c, input logic a12);
    logic r;
    r = 1'b1;
    case (c.bmode)
      BM_FIX8: r = 1'b1;
      BM_OTF: r = a12;
      BM_CHOP4: r = 1'b0;
      default: r = 1'b1;
    endcase
    return r;
  endfunction

  // One lane of one beat: returns {store enable, data}
  function automatic logic [8:0] lane_store(input dwb_cfg_s c, input logic dm_n,
                                            input logic [7:0] d);
    logic mask_on;
    logic [8:0] r;
    mask_on = HAS_MASK & c.mask_en & ~c.inv_en;
    r = {1'b1, d};
    if (c.inv_en && !dm_n) begin
      r = {1'b1, ~d};
    end else if (mask_on && !dm_n) begin
      r = {1'b0, d};
    end
    return r;
  endfunction

  // ------------------------------------------------------------
  // Link reset release
  // ------------------------------------------------------------
  // Async assert, release aligned to the link clock
  always_ff @(posedge I_LCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      lrst_q <= 2'h0;
    end else begin
      lrst_q <= {lrst_q[0], 1'b1};
    end
  end
  assign lrst_n = lrst_q[1];

  // ------------------------------------------------------------
  // Link domain: latency line, capture, banks
  // ------------------------------------------------------------
  // Next-state for everything on the link clock
  always_comb begin
    l_d = l_q;
    // Config is quasi-static: per-bit two-flop crossing is enough
    l_d.cfg_m = s_q.cfg;
    l_d.cfg_l = l_q.cfg_m;
    wl = {1'b0, l_q.cfg_l.al} + {1'b0, l_q.cfg_l.write_column_latency};
    wl_idx = wl[4:0] - 5'h01;
    tap = l_q.dl[wl_idx];
    new_cmd.valid = (I_CMD == DWB_WR);
    new_cmd.bl8 = burst_is8(l_q.cfg_l, I_A12);
    new_cmd.ac = I_A10;
    new_cmd.bank = I_BANK;
    new_cmd.slot = I_SLOT;
    l_d.dl = {l_q.dl[DL_DEPTH-2:0], new_cmd};
    start = tap.valid;
    cap = start | l_q.busy;
    cc = start ? tap : l_q.cur;
    pidx = start ? 2'h0 : l_q.pair;
    done = cap && (pidx == (cc.bl8 ? PAIR_LAST_8 : PAIR_LAST_4));
    l_d.cur = cc;
    l_d.pair = pidx + 2'h1;
    l_d.busy = cap & ~done;
    if (done) begin
      l_d.tgl = ~l_q.tgl;
    end
    waddr = {cc.bank, cc.slot, pidx, 1'b0};
    {we0, wd0} = lane_store(l_q.cfg_l, I_MASK_N[0], I_DQ[7:0]);
    {we1, wd1} = lane_store(l_q.cfg_l, I_MASK_N[1], I_DQ[15:8]);
    we0 = we0 & cap;
    we1 = we1 & cap;
    // Bank bookkeeping
    for (int b = 0; b < BANKS; b++) begin
      if (l_q.pend[b]) begin
        if (l_q.rec[b] == 5'h00) begin
          l_d.pend[b] = 1'b0;
          l_d.open[b] = 1'b0;
        end else begin
          l_d.rec[b] = l_q.rec[b] - 5'h01;
        end
      end
      if (done && cc.ac && cc.bank == 2'(b)) begin
        l_d.pend[b] = 1'b1;
        l_d.rec[b] = l_q.cfg_l.wr_rec - 5'h01;
      end
      if (I_BANK == 2'(b) && I_CMD == DWB_ACT) begin
        l_d.open[b] = 1'b1;
      end
      if (I_BANK == 2'(b) && I_CMD == DWB_PRE) begin
        l_d.open[b] = 1'b0;
        l_d.pend[b] = 1'b0;
      end
    end
    // Controller-side spacing and column latency watch, sticky until reset
    if (new_cmd.valid) begin
      l_d.gap = 3'h0;
    end else if (l_q.gap != GAP_SAT) begin
      l_d.gap = l_q.gap + 3'h1;
    end
    if (new_cmd.valid && l_q.cfg_l.pre2 && l_q.gap == GAP_FIVE) begin
      l_d.err[0] = 1'b1;
    end
    if (new_cmd.valid && l_q.cfg_l.pre2 && l_q.cfg_l.write_column_latency <= CWL_LOWEST) begin
      l_d.err[1] = 1'b1;
    end
    l_d.peek = mem[I_PEEK_ADDR];
  end

  // Link state register
  always_ff @(posedge I_LCLK or negedge lrst_n) begin
    if (!lrst_n) begin
      l_q <= LNK_RST;
    end else begin
      l_q <= l_d;
    end
  end

  // Array: two byte lanes per link clock, one per beat
  always_ff @(posedge I_LCLK) begin
    if (we0) begin
      mem[waddr] <= wd0;
    end
    if (we1) begin
      mem[{waddr[6:1], 1'b1}] <= wd1;
    end
  end

  // ------------------------------------------------------------
  // System domain: Avalon-MM slave and status crossing
  // ------------------------------------------------------------
  // Answer one cycle after the request; read data and waitrequest low together
  always_comb begin
    logic [31:0] merged;
    logic [31:0] stat;
    merged = 32'(s_q.cfg);
    stat = '0;
    s_d = s_q;
    s_d.wtreq = 1'b1;
    s_d.open_m = l_q.open;
    s_d.open_s = s_q.open_m;
    s_d.err_m = l_q.err;
    s_d.err_s = s_q.err_m;
    s_d.tg = {s_q.tg[1:0], l_q.tgl};
    // Toggle edge: one finished burst
    if (s_q.tg[2] ^ s_q.tg[1]) begin
      s_d.bursts = s_q.bursts + 16'h0001;
    end
    stat[ST_OPEN +: 4] = s_q.open_s;
    stat[ST_CRC_PERSIST] = s_q.cfg.crc_en & s_q.cfg.mask_en;
    stat[ST_MASK_ACTIVE] = HAS_MASK & s_q.cfg.mask_en & ~s_q.cfg.inv_en;
    stat[ST_GAP_ERR] = s_q.err_s[0];
    stat[ST_CWL_ERR] = s_q.err_s[1];
    for (int i = 0; i < 4; i++) begin
      if (I_BYTEENABLE[i]) begin
        merged[8*i +: 8] = I_WRITEDATA[8*i +: 8];
      end
    end
    // Writes land at the edge where the master samples waitrequest low
    if (I_WRITE && !s_q.wtreq && I_ADDRESS == OFS_CFG) begin
      s_d.cfg = dwb_cfg_s'(merged[CFG_W-1:0]);
    end
    if ((I_READ || I_WRITE) && s_q.wtreq) begin
      s_d.wtreq = 1'b0;
      s_d.rdata = '0;
      if (I_READ) begin
        case (I_ADDRESS)
          OFS_CFG: s_d.rdata = 32'(s_q.cfg);
          OFS_STAT: s_d.rdata = stat;
          OFS_BURSTS: s_d.rdata = 32'(s_q.bursts);
          default: s_d.rdata = '0;
        endcase
      end
    end
  end

  // System state register
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      s_q <= SYS_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flip-flops
  assign O_WAITREQUEST = s_q.wtreq;
  assign O_READDATA = s_q.rdata;
  assign O_BANK_OPEN = l_q.open;
  assign O_PEEK_DATA = l_q.peek;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_bl8_four_pairs: assert property (
    @(posedge I_LCLK) disable iff (!lrst_n)
    start && tap.bl8 |=> l_q.busy && l_q.pair == 2'h1 ##1 l_q.pair == 2'h2
      ##1 l_q.pair == 2'h3)
    else $error("eight-beat burst did not run four pairs");

  a_chop_two_pairs: assert property (
    @(posedge I_LCLK) disable iff (!lrst_n)
    start && !tap.bl8 |=> l_q.busy ##1 (!l_q.busy || $past(start)))
    else $error("chopped burst captured more than two pairs");

  a_fixed_chop_mode: assert property (
    @(posedge I_LCLK) disable iff (!lrst_n)
    I_CMD == DWB_WR && l_q.cfg_l.bmode == BM_CHOP4 |=> !l_q.dl[0].bl8)
    else $error("fixed chop mode gave eight beats");

  a_otf_length_bit: assert property (
    @(posedge I_LCLK) disable iff (!lrst_n)
    I_CMD == DWB_WR && l_q.cfg_l.bmode == BM_OTF
      |=> l_q.dl[0].valid && l_q.dl[0].bl8 == $past(I_A12))
    else $error("per-command length not taken from bit 12");

  a_mask_discards: assert property (
    @(posedge I_LCLK) disable iff (!lrst_n)
    cap && l_q.cfg_l.mask_en && !l_q.cfg_l.inv_en && !I_MASK_N[1] |-> !we1)
    else $error("masked lane was written");

  a_unmasked_store: assert property (
    @(posedge I_LCLK) disable iff (!lrst_n)
    cap && I_MASK_N[0] |-> we0 && wd0 == I_DQ[7:0])
    else $error("unmasked lane not stored as received");

  a_inv_no_mask: assert property (
    @(posedge I_LCLK) disable iff (!lrst_n)
    cap && l_q.cfg_l.inv_en && !I_MASK_N[0] |-> we0 && wd0 == ~I_DQ[7:0])
    else $error("inversion lane masked or not inverted");

  a_autoclose_arm: assert property (
    @(posedge I_LCLK) disable iff (!lrst_n)
    done && cc.ac && !(I_CMD == DWB_PRE && I_BANK == cc.bank)
      |=> l_q.pend[$past(cc.bank)]
      && l_q.rec[$past(cc.bank)] == $past(l_q.cfg_l.wr_rec) - 5'h01)
    else $error("write with close did not arm recovery");

  a_plain_stays_open: assert property (
    @(posedge I_LCLK) disable iff (!lrst_n)
    done && !cc.ac && l_q.open[cc.bank] && !l_q.pend[cc.bank]
      && I_CMD != DWB_PRE |=> l_q.open[$past(cc.bank)])
    else $error("plain write closed its bank");

  a_wait_one_cycle: assert property (
    @(posedge I_CLK) disable iff (!I_RST_N)
    (I_READ || I_WRITE) && s_q.wtreq |=> !s_q.wtreq ##1 s_q.wtreq)
    else $error("waitrequest low not exactly one cycle");

endmodule

/* File: bench/dwb_ctrl_model.sv */
/*
  Behavioural memory controller: commands, beat pairs and the shared mask
  pin, all launched on the link clock. Assumes the bench books slots at
  least two link edges ahead of the current count.
*/
`timescale 1ns/1ns
module dwb_ctrl_model
  import dwb_pkg::*;
(
  input wire logic i_lclk,
  output logic [1:0] o_cmd,
  output logic [1:0] o_bank,
  output logic [1:0] o_slot,
  output logic o_a10,
  output logic o_a12,
  output logic [15:0] o_dq,
  output logic [1:0] o_mask_n
);
  // Slot tables indexed by link edge count modulo 64
  logic [1:0] cmd_t [64];
  logic [5:0] arg_t [64];
  logic [15:0] dq_t [64];
  logic [1:0] msk_t [64];
  int n = 0;

  initial begin
    for (int i = 0; i < 64; i++) begin
      cmd_t[i] = DWB_NOP;
      arg_t[i] = i[5:0];
      dq_t[i] = {i[7:0], ~i[7:0]};
      msk_t[i] = i[1:0];
    end
    {o_cmd, o_bank, o_slot, o_a10, o_a12, o_dq, o_mask_n} = '0;
  end

  // Idle slots refill with a moving pattern so stale data never looks valid
  always @(posedge i_lclk) begin
    o_cmd <= cmd_t[(n + 1) % 64];
    {o_bank, o_slot, o_a10, o_a12} <= arg_t[(n + 1) % 64];
    o_dq <= dq_t[(n + 1) % 64];
    o_mask_n <= msk_t[(n + 1) % 64];
    cmd_t[(n + 1) % 64] <= DWB_NOP;
    arg_t[(n + 1) % 64] <= n[5:0];
    dq_t[(n + 1) % 64] <= {n[7:0], ~n[7:0]};
    msk_t[(n + 1) % 64] <= n[1:0];
    n <= n + 1;
  end

  // no link reads issued, so no turnaround due
  task automatic put_cmd(input int at, input logic [1:0] c, input logic [5:0] a);
    cmd_t[at % 64] = c;
    arg_t[at % 64] = a;
  endtask

  // own length bit, latency, legal spacing
  task automatic put_wr(input int at, input logic [3:0] bs, input logic a10, input logic a12,
      input int wl, input int np, input logic [63:0] d, input logic [7:0] m);
    put_cmd(at, DWB_WR, {bs, a10, a12});
    for (int p = 0; p < np; p++) begin
      dq_t[(at + wl + p) % 64] = d[p * 16 +: 16];
      msk_t[(at + wl + p) % 64] = m[p * 2 +: 2];
    end
  endtask
endmodule

/* File: bench/tb_top.sv */
/*
  Self-checking bench for the write burst path: Avalon-MM register tasks,
  link traffic through the controller model, array read-back by peeking.
  Assumes dwb_pkg and the controller model are compiled first.
*/
`timescale 1ns/1ns
module tb_top;
  import dwb_pkg::*;
  localparam logic [63:0] PA = 64'h0123456789ABCDEF;
  localparam logic [63:0] PB = 64'hF0E1D2C3B4A59687;
  localparam logic [63:0] PC = 64'h1122334455667788;
  localparam logic [63:0] PD = 64'h99AABBCCDDEEFF00;
  localparam logic [63:0] PE = 64'h3C4B5A6978879695;
  logic clk = 1'b0;
  logic lclk = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] adr = 5'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [3:0] ben = 4'hF;
  logic wait_rq;
  logic [31:0] rdat;
  logic [1:0] cmd, bank, slot, msk;
  logic a10, a12;
  logic [15:0] dq;
  logic [6:0] peek = 7'h00;
  logic [3:0] open;
  logic [7:0] pdat;
  int fails = 0;
  int cmp_count = 0;
  int t0;
  logic [31:0] q;
  logic [63:0] m, e;
  dwb_cfg_s c;

  // 20 MHz system clock, 32 ns link clock with unrelated phase
  always #25 clk = ~clk;
  always #16 lclk = ~lclk;

  dwb_write_path DUT (.I_CLK(clk), .I_RST_N(rst_n), .I_ADDRESS(adr), .I_READ(rd),
    .I_WRITE(wr), .I_WRITEDATA(wdat), .I_BYTEENABLE(ben), .O_WAITREQUEST(wait_rq),
    .O_READDATA(rdat), .I_LCLK(lclk), .I_CMD(cmd), .I_BANK(bank), .I_SLOT(slot),
    .I_A10(a10), .I_A12(a12), .I_DQ(dq), .I_MASK_N(msk), .I_PEEK_ADDR(peek),
    .O_BANK_OPEN(open), .O_PEEK_DATA(pdat));

  dwb_ctrl_model u_ctl (.i_lclk(lclk), .o_cmd(cmd), .o_bank(bank), .o_slot(slot),
    .o_a10(a10), .o_a12(a12), .o_dq(dq), .o_mask_n(msk));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Request held until waitrequest is sampled low, released after that edge
  task automatic av(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    adr <= a;
    wdat <= d;
    wr <= w;
    rd <= !w;
    // Only the watchdog ends a wait that never gets its answer
    do begin
      @(posedge clk);
    end while (wait_rq !== 1'b0);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  task automatic setcfg(input logic [1:0] bm, input logic mk, input logic inv, input logic crc,
      input logic [4:0] al);
    c = CFG_RST;
    c.bmode = bm;
    c.mask_en = mk;
    c.inv_en = inv;
    c.crc_en = crc;
    c.al = al;
    av(1'b1, OFS_CFG, {11'h000, c});
    // Config crosses bit by bit, so let it settle before link traffic
    repeat (4) @(posedge lclk);
    t0 = u_ctl.n + 3;
  endtask

  task automatic upto(input int t);
    while (u_ctl.n < t) @(posedge lclk);
  endtask

  task automatic peek8(input logic [3:0] bs);
    for (int i = 0; i < 8; i++) begin
      @(posedge lclk);
      peek <= {bs, i[2:0]};
      repeat (2) @(posedge lclk);
      m[i * 8 +: 8] = pdat;
    end
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic s_regs;
    av(1'b0, OFS_CFG, 32'h0);
    chk("cfg reset", q, {11'h000, CFG_RST});
    av(1'b0, 5'h0C, 32'h0);
    chk("unmapped read", q, 64'h0);
  endtask

  // Fixed eight ignores a low bit 12; two writes four apart run seamless
  task automatic s_fix8;
    setcfg(BM_FIX8, 1'b0, 1'b0, 1'b0, 5'h00);
    u_ctl.put_cmd(t0, DWB_ACT, 6'h00);
    u_ctl.put_cmd(t0 + 1, DWB_ACT, 6'h10);
    u_ctl.put_cmd(t0 + 2, DWB_ACT, 6'h20);
    u_ctl.put_wr(t0 + 4, 4'h0, 1'b0, 1'b0, 9, 4, PA, 8'hFF);
    u_ctl.put_wr(t0 + 8, 4'h8, 1'b0, 1'b1, 9, 4, PB, 8'hFF);
    upto(t0 + 24);
    peek8(4'h0);
    chk("eight beats bank0", m, PA);
    peek8(4'h8);
    chk("seamless bank2", m, PB);
    chk("banks stay open", open, 4'b0111);
  endtask

  task automatic s_otf;
    setcfg(BM_OTF, 1'b0, 1'b0, 1'b0, 5'h00);
    u_ctl.put_wr(t0, 4'h4, 1'b0, 1'b1, 9, 4, PD, 8'hFF);
    u_ctl.put_wr(t0 + 4, 4'h8, 1'b0, 1'b0, 9, 2, PC, 8'hFF);
    upto(t0 + 20);
    peek8(4'h4);
    chk("per-command eight", m, PD);
    peek8(4'h8);
    chk("per-command chop", m, {PB[63:32], PC[31:0]});
  endtask

  // Chop mode with bit 12 high and four pairs offered keeps only two
  task automatic s_chop;
    setcfg(BM_CHOP4, 1'b0, 1'b0, 1'b0, 5'h00);
    u_ctl.put_wr(t0, 4'h4, 1'b0, 1'b1, 9, 4, PE, 8'hFF);
    upto(t0 + 16);
    peek8(4'h4);
    chk("fixed chop", m, {PD[63:32], PE[31:0]});
  endtask

  task automatic s_mask;
    setcfg(BM_FIX8, 1'b1, 1'b0, 1'b1, 5'h00);
    // Book the write before the status read so its slot is still ahead
    u_ctl.put_wr(t0, 4'h0, 1'b0, 1'b1, 9, 4, PC, 8'hA5);
    av(1'b0, OFS_STAT, 32'h0);
    chk("crc persistent", q[ST_CRC_PERSIST], 64'h1);
    chk("mask active", q[ST_MASK_ACTIVE], 64'h1);
    upto(t0 + 16);
    for (int i = 0; i < 8; i++) begin
      e[i * 8 +: 8] = (8'hA5 >> i) & 8'h01 ? PC[i * 8 +: 8] : PA[i * 8 +: 8];
    end
    peek8(4'h0);
    chk("masked lanes", m, e);
    setcfg(BM_FIX8, 1'b1, 1'b1, 1'b0, 5'h00);
    // Flag low on the upper four beats: stored inverted, never dropped
    u_ctl.put_wr(t0, 4'h1, 1'b0, 1'b1, 9, 4, PA, 8'h0F);
    av(1'b0, OFS_STAT, 32'h0);
    chk("mask off with inversion", q[ST_MASK_ACTIVE], 64'h0);
    chk("crc mode off", q[ST_CRC_PERSIST], 64'h0);
    upto(t0 + 16);
    peek8(4'h1);
    chk("inverted lanes", m, {~PA[63:32], PA[31:0]});
  endtask

  // Latency 10 plus 9; last pair at t0+24, close recovery edges later
  task automatic s_close;
    setcfg(BM_FIX8, 1'b0, 1'b0, 1'b1, 5'h0A);
    u_ctl.put_cmd(t0, DWB_ACT, 6'h30);
    u_ctl.put_wr(t0 + 2, 4'hF, 1'b1, 1'b1, 19, 4, PE, 8'hFF);
    av(1'b0, OFS_STAT, 32'h0);
    chk("crc non-persistent", q[ST_CRC_PERSIST], 64'h0);
    // Close lands exactly recovery edges after the last pair's edge
    upto(t0 + 24 + WR_RST);
    chk("open until recovery", open[3], 64'h1);
    upto(t0 + 25 + WR_RST);
    chk("closed after burst", open, 4'b0111);
    peek8(4'hF);
    chk("latency 19 data", m, PE);
    av(1'b0, OFS_BURSTS, 32'h0);
    chk("finished bursts", q, 64'h8);
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    s_regs;
    s_fix8;
    s_otf;
    s_chop;
    s_mask;
    s_close;
    end_sim;
  end

  // Tests need about 415 link clocks; allow roughly fifteen times that
  initial begin
    #200000;
    fails++;
    end_sim;
  end
endmodule
